/* File: src/clkctl_core.sv */
// Module: core clock domain lane identity, subclass and reference sampling
//
// Contract
// - Four octets per core cycle on each lane over a 32-bit datapath.
// - Core clock is octet clock over four, line rate over forty.
// - All lanes share one bit rate, ten times the octet clock.
// - Octet rate equals frame rate times octets per frame.
// - Both ends use the same frame and multiframe periods.
// - At most eight lanes per instance; wider links use more instances.
// - Transmit lane identifiers are set by software per lane independently.
// - Transmitter accepts identical identifiers, including zero, on all lanes.
// - Receive lane identifier is readable from captured configuration word three.
// - Configuration clock is asynchronous; every crossing is synchronised.
// - Reference pulse and transmit sync are sampled in core clock domain.
// - Software subclass select 0, 1 or 2; reset value subclass 1.
// - Subclass 1 works with single, periodic or gapped reference.
`timescale 1ns/1ns
`default_nettype none
module clkctl_core
  import clkctl_pkg::*;
#(
  parameter int LANES     = MAX_LANES,
  parameter int STABLE_CY = STABLE_CYCLES
)
(
  input  wire logic                                   cfg_clk,
  input  wire logic                                   cfg_rst,
  input  wire logic [1:0]                             cfg_subclass,
  input  wire logic [LANES*clkctl_pkg::LID_WIDTH-1:0] cfg_tx_lid,
  input  wire logic                                   cfg_load,
  output logic                                        cfg_busy,
  output logic [LANES*clkctl_pkg::LID_WIDTH-1:0]      cfg_rx_lid,
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  wire logic                                   serdes_power_good,
  input  wire logic                                   sysref_in,
  input  wire logic                                   sync_in,
  input  wire logic [LANES*clkctl_pkg::LID_WIDTH-1:0] ila_cfg_word3,
  input  wire logic [LANES-1:0]                       ila_cfg_valid,
  input  wire logic [LANES*clkctl_pkg::DATA_WIDTH-1:0] tx_data_in,
  output logic [LANES*clkctl_pkg::DATA_WIDTH-1:0]     tx_data_out,
  output logic [LANES*clkctl_pkg::LID_WIDTH-1:0]      tx_lane_identifier_field,
  output logic [1:0]                                  core_subclass,
  output logic                                        core_ready,
  output logic                                        lmfc_event,
  output logic                                        sync_capture
);
  import clkctl_pkg::*;

  // ==========================================================================
  // Geometry checks
  localparam int LW = LANES * LID_WIDTH;
  localparam int DW = LANES * DATA_WIDTH;
  localparam int LANES_OK = (LANES >= 1 && LANES <= MAX_LANES) ? 1 : 0;
  // Bad LANES fails elaboration: an unpacked array may not have size zero
  logic lanes_ok_dummy [LANES_OK];
  assign lanes_ok_dummy[0] = 1'b0;

  // ==========================================================================
  // Core reset release after power good is stable
  logic [SYNC_STAGES-1:0]      pg_sync;
  logic [STABLE_CNT_WIDTH-1:0] stable_cnt;
  logic                        core_rst;
  wire pg_ok = pg_sync[1] & pg_sync[2];
  wire stable_done = (stable_cnt == STABLE_CNT_WIDTH'(STABLE_CY));

  always_ff @(posedge clk or posedge rst)
    if (rst)
      pg_sync <= '0;
    else
      pg_sync <= {pg_sync[SYNC_STAGES-2:0], serdes_power_good};

  // Any power-good drop restarts the count, so a glitching serdes holds reset
  always_ff @(posedge clk or posedge rst)
    if (rst)
      stable_cnt <= '0;
    else if (!pg_ok)
      stable_cnt <= '0;
    else if (!stable_done)
      stable_cnt <= stable_cnt + STABLE_CNT_WIDTH'(1);

  always_ff @(posedge clk or posedge rst)
    if (rst)
      core_rst <= 1'b1;
    else
      core_rst <= !(pg_ok && stable_done);

  always_ff @(posedge clk or posedge rst)
    if (rst)
      core_ready <= 1'b0;
    else
      core_ready <= !core_rst;

  // ==========================================================================
  // Configuration side handshake source
  logic [1:0]  hold_subclass;
  logic [LW-1:0] hold_lid;
  logic        req_tgl;
  logic        ack_tgl;
  logic [2:0]  ack_sync;
  clkctl_hs_e  hs_state;
  clkctl_hs_e  next_hs_state;
  wire ack_seen = (ack_sync[2] == req_tgl);

  always_comb
  begin
    next_hs_state = hs_state;
    case (hs_state)
      CLKCTL_IDLE: if (cfg_load) next_hs_state = CLKCTL_REQ;
      CLKCTL_REQ:  next_hs_state = CLKCTL_WAIT;
      CLKCTL_WAIT: if (ack_seen) next_hs_state = CLKCTL_IDLE;
      default:     next_hs_state = CLKCTL_IDLE;
    endcase
  end

  always_ff @(posedge cfg_clk or posedge cfg_rst)
    if (cfg_rst)
      hs_state <= CLKCTL_IDLE;
    else
      hs_state <= next_hs_state;

  // Held words stay still while a request is in flight
  always_ff @(posedge cfg_clk or posedge cfg_rst)
    if (cfg_rst)
    begin
      hold_subclass <= SUBCLASS_RESET;
      hold_lid      <= '0;
    end
    else if (hs_state == CLKCTL_IDLE && cfg_load)
    begin
      hold_subclass <= (cfg_subclass > SUBCLASS_2) ? hold_subclass : cfg_subclass;
      hold_lid      <= cfg_tx_lid;
    end

  always_ff @(posedge cfg_clk or posedge cfg_rst)
    if (cfg_rst)
      req_tgl <= 1'b0;
    else if (hs_state == CLKCTL_REQ)
      req_tgl <= ~req_tgl;

  always_ff @(posedge cfg_clk or posedge cfg_rst)
    if (cfg_rst)
      ack_sync <= '0;
    else
      ack_sync <= {ack_sync[1:0], ack_tgl};

  always_ff @(posedge cfg_clk or posedge cfg_rst)
    if (cfg_rst)
      cfg_busy <= 1'b0;
    else
      cfg_busy <= (next_hs_state != CLKCTL_IDLE);

  // ==========================================================================
  // Core side handshake sink
  logic [2:0] req_sync;
  wire new_req = (req_sync[1] == req_sync[2]) && (req_sync[2] != ack_tgl);

  always_ff @(posedge clk or posedge rst)
    if (rst)
      req_sync <= '0;
    else
      req_sync <= {req_sync[1:0], req_tgl};

  // Ack toggles even during core reset so the config side never hangs
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ack_tgl <= 1'b0;
    else if (new_req)
      ack_tgl <= req_sync[2];

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      core_subclass            <= SUBCLASS_RESET;
      tx_lane_identifier_field <= '0;
    end
    else if (new_req)
    begin
      core_subclass            <= hold_subclass;
      // Same value on every lane, zero included, is legal
      tx_lane_identifier_field <= hold_lid;
    end

  // ==========================================================================
  // Reference and sync sampling in the core domain
  logic [SYNC_STAGES-1:0] sysref_sync;
  logic [SYNC_STAGES-1:0] syncn_sync;
  logic                   sysref_level;
  logic                   sync_level;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      sysref_sync <= '0;
      syncn_sync  <= '0;
    end
    else
    begin
      sysref_sync <= {sysref_sync[SYNC_STAGES-2:0], sysref_in};
      syncn_sync  <= {syncn_sync[SYNC_STAGES-2:0], sync_in};
    end

  wire sysref_agree = (sysref_sync[1] == sysref_sync[2]);
  wire sync_agree   = (syncn_sync[1] == syncn_sync[2]);

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      sysref_level <= 1'b0;
      sync_level   <= 1'b0;
    end
    else
    begin
      if (sysref_agree)
        sysref_level <= sysref_sync[2];
      if (sync_agree)
        sync_level <= syncn_sync[2];
    end

  wire sysref_rise = sysref_agree && sysref_sync[2] && !sysref_level;
  wire sync_rise   = sync_agree && syncn_sync[2] && !sync_level;
  // Each rising edge in the matching subclass, outside core reset, is an event; one-shot, periodic and gapped all look alike
  wire sysref_use  = sysref_rise && (core_subclass == SUBCLASS_1) && !core_rst;
  wire sync_use    = sync_rise && (core_subclass == SUBCLASS_2) && !core_rst;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      lmfc_event   <= 1'b0;
      sync_capture <= 1'b0;
    end
    else
    begin
      lmfc_event   <= sysref_use;
      sync_capture <= sync_use;
    end

  // ==========================================================================
  // Per-lane datapath and captured identifiers
  logic [LW-1:0] core_rx_lid;
  logic [2:0]    rx_tgl_sync;
  logic          rx_tgl;

  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      always_ff @(posedge clk or posedge rst)
        if (rst)
          tx_data_out[g*DATA_WIDTH +: DATA_WIDTH] <= '0;
        else if (core_rst)
          tx_data_out[g*DATA_WIDTH +: DATA_WIDTH] <= '0;
        else
          tx_data_out[g*DATA_WIDTH +: DATA_WIDTH] <=
            tx_data_in[g*DATA_WIDTH +: DATA_WIDTH];

      always_ff @(posedge clk or posedge rst)
        if (rst)
          core_rx_lid[g*LID_WIDTH +: LID_WIDTH] <= '0;
        else if (ila_cfg_valid[g] && !core_rst)
          core_rx_lid[g*LID_WIDTH +: LID_WIDTH] <=
            ila_cfg_word3[g*LID_WIDTH + ILA_LID_LSB +: LID_WIDTH];
    end
  endgenerate

  // Identifier update toggles; the words are steady by the time it is seen
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rx_tgl <= 1'b0;
    else if (|ila_cfg_valid)
      rx_tgl <= ~rx_tgl;

  always_ff @(posedge cfg_clk or posedge cfg_rst)
    if (cfg_rst)
      rx_tgl_sync <= '0;
    else
      rx_tgl_sync <= {rx_tgl_sync[1:0], rx_tgl};

  logic rx_tgl_seen;
  always_ff @(posedge cfg_clk or posedge cfg_rst)
    if (cfg_rst)
      rx_tgl_seen <= 1'b0;
    else
      rx_tgl_seen <= rx_tgl_sync[2];

  always_ff @(posedge cfg_clk or posedge cfg_rst)
    if (cfg_rst)
      cfg_rx_lid <= '0;
    else if (rx_tgl_seen != rx_tgl_sync[2])
      cfg_rx_lid <= core_rx_lid;

endmodule : clkctl_core
`default_nettype wire

/* File: src/clkctl_pkg.sv */
// Package: constants for the converter link clocking and lane identity block
package clkctl_pkg;
  // ==========================================================================
  // Datapath geometry
  localparam int OCTETS_PER_CYCLE = 4;
  localparam int OCTET_BITS       = 8;
  localparam int DATA_WIDTH       = OCTETS_PER_CYCLE * OCTET_BITS;
  localparam int BITS_PER_OCTET   = 10;
  localparam int LINE_DIVIDE      = BITS_PER_OCTET * OCTETS_PER_CYCLE;
  localparam int MAX_LANES        = 8;
  localparam int LID_WIDTH        = 5;
  localparam int OCTET_CNT_WIDTH  = 8;
  // ==========================================================================
  // Captured configuration layout: word 3 holds the lane identifier
  localparam int ILA_LID_WORD     = 3;
  localparam int ILA_LID_LSB      = 0;
  // ==========================================================================
  // Subclass
  localparam logic [1:0] SUBCLASS_0     = 2'h0;
  localparam logic [1:0] SUBCLASS_1     = 2'h1;
  localparam logic [1:0] SUBCLASS_2     = 2'h2;
  localparam logic [1:0] SUBCLASS_RESET = SUBCLASS_1;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 20;
  localparam int STABLE_TIME_NS   = 1000;
  localparam int STABLE_CYCLES    =
    (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STABLE_CNT_WIDTH = 8;
  localparam int SYNC_STAGES      = 3;
  // ==========================================================================
  // Configuration crossing handshake states
  typedef enum logic [2:0]
  {
    CLKCTL_IDLE = 3'b001,
    CLKCTL_REQ  = 3'b010,
    CLKCTL_WAIT = 3'b100
  } clkctl_hs_e;
endpackage : clkctl_pkg

/* File: sim/clkctl_checker.sv */
// Checker: concurrent assertions on the core clocking block ports
`timescale 1ns/1ns
`default_nettype none
module clkctl_checker
  import clkctl_pkg::*;
#(
  parameter int LANES     = 2,
  parameter int STABLE_CY = 4
)
(
  input wire logic                                    cfg_clk,
  input wire logic                                    cfg_rst,
  input wire logic                                    cfg_load,
  input wire logic                                    cfg_busy,
  input wire logic                                    clk,
  input wire logic                                    rst,
  input wire logic                                    serdes_power_good,
  input wire logic                                    sysref_in,
  input wire logic                                    sync_in,
  input wire logic [LANES*clkctl_pkg::DATA_WIDTH-1:0] tx_data_in,
  input wire logic [LANES*clkctl_pkg::DATA_WIDTH-1:0] tx_data_out,
  input wire logic [1:0]                              core_subclass,
  input wire logic                                    core_ready,
  input wire logic                                    lmfc_event,
  input wire logic                                    sync_capture
);
  // ==========================================================================
  // Helper: consecutive cycles of power good at the pin
  logic [7:0] pg_cnt;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pg_cnt <= 8'h00;
    else if (!serdes_power_good)
      pg_cnt <= 8'h00;
    else if (pg_cnt != 8'hFF)
      pg_cnt <= pg_cnt + 8'h01;
  end
  // ==========================================================================
  // Accepted edges
  sequence ref_rise_s;
    $rose(sysref_in) && core_ready && core_subclass == SUBCLASS_1;
  endsequence
  sequence sync_rise_s;
    $rose(sync_in) && core_ready && core_subclass == SUBCLASS_2;
  endsequence
  // ==========================================================================
  // Properties
  ref_event_a: assert property (@(posedge clk) disable iff (rst)
    ref_rise_s |-> ##[2:6] lmfc_event) else $error("reference edge lost");
  sync_event_a: assert property (@(posedge clk) disable iff (rst)
    sync_rise_s |-> ##[2:6] sync_capture) else $error("sync edge lost");
  event_pulse_a: assert property (@(posedge clk) disable iff (rst)
    lmfc_event || sync_capture |=> !lmfc_event && !sync_capture)
    else $error("event longer than one cycle");
  sc0_quiet_a: assert property (@(posedge clk) disable iff (rst)
    core_subclass == SUBCLASS_0 |-> !lmfc_event && !sync_capture)
    else $error("event in subclass 0");
  subclass_legal_a: assert property (@(posedge clk) disable iff (rst)
    core_subclass != 2'h3) else $error("illegal subclass");
  ready_wait_a: assert property (@(posedge clk) disable iff (rst)
    $rose(core_ready) |-> pg_cnt >= STABLE_CY) else $error("ready too early");
  data_zero_a: assert property (@(posedge clk) disable iff (rst)
    !core_ready ##1 !core_ready |-> tx_data_out == '0) else $error("data in reset");
  data_pass_a: assert property (@(posedge clk) disable iff (rst)
    core_ready && $past(core_ready) |-> tx_data_out == $past(tx_data_in))
    else $error("data not passed");
  load_busy_a: assert property (@(posedge cfg_clk) disable iff (cfg_rst)
    cfg_load && !cfg_busy |=> cfg_busy) else $error("load not taken");
endmodule : clkctl_checker
bind clkctl_core clkctl_checker #(.LANES(LANES), .STABLE_CY(STABLE_CY)) chk (.cfg_clk,
  .cfg_rst, .cfg_load, .cfg_busy, .clk, .rst, .serdes_power_good, .sysref_in, .sync_in,
  .tx_data_in, .tx_data_out, .core_subclass, .core_ready, .lmfc_event, .sync_capture);
`default_nettype wire

/* File: sim/clkctl_conv_model.sv */
// Converter-side model: reference pulses, sync and captured lane identifiers
`timescale 1ns/1ns
`default_nettype none
module clkctl_conv_model
  import clkctl_pkg::*;
#(
  parameter int LANES = 2
)
(
  input  wire logic                                   clk,
  output logic                                        sysref_in,
  output logic                                        sync_in,
  output logic [LANES*clkctl_pkg::LID_WIDTH-1:0]      ila_cfg_word3,
  output logic [LANES-1:0]                            ila_cfg_valid
);
  initial
  begin
    sysref_in = 1'b0;
    sync_in = 1'b0;
    ila_cfg_word3 = '0;
    ila_cfg_valid = '0;
  end
  // Odd periods stretched by gap give the gapped form; same period both ends
  task automatic ref_train(input int n, input int period, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk) sysref_in = 1'b1;
      repeat (4) @(negedge clk);
      sysref_in = 1'b0;
      repeat (period + (i % 2) * gap) @(negedge clk);
    end
  endtask : ref_train
  task automatic sync_rise;
    @(negedge clk) sync_in = 1'b1;
    repeat (6) @(negedge clk);
    sync_in = 1'b0;
    repeat (10) @(negedge clk);
  endtask : sync_rise
  task automatic send_ila(input int lane, input logic [LID_WIDTH-1:0] lane_identifier_field);
    @(negedge clk);
    ila_cfg_word3[lane*LID_WIDTH +: LID_WIDTH] = lane_identifier_field;
    ila_cfg_valid[lane] = 1'b1;
    @(negedge clk);
    ila_cfg_valid[lane] = 1'b0;
    // Stale field must not look valid
    ila_cfg_word3 = ~ila_cfg_word3;
  endtask : send_ila
endmodule : clkctl_conv_model
`default_nettype wire

/* File: sim/test_clkctl_core.sv */
// Testbench: core clocking, subclass, lane identifier and reference sampling
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_clkctl_core;
  import clkctl_pkg::*;
  localparam int LANES = 2;
  localparam int STABLE = 4;
  localparam int LW = LANES * LID_WIDTH;
  logic clk = 1'b0, cfg_clk = 1'b0, rst = 1'b1, cfg_rst = 1'b1, pg = 1'b0, cfg_load = 1'b0;
  logic [1:0] cfg_subclass = 2'h0;
  logic [LW-1:0] cfg_tx_lid = '0;
  logic [LANES*DATA_WIDTH-1:0] tx_data_in = '0;
  logic cfg_busy, core_ready, lmfc_event, sync_capture, sysref_in, sync_in;
  logic [LW-1:0] cfg_rx_lid, tx_lid, ila_cfg_word3;
  logic [LANES-1:0] ila_cfg_valid;
  logic [LANES*DATA_WIDTH-1:0] tx_data_out;
  logic [1:0] core_subclass;
  int bad_count = 0, n_checks = 0, n_lmfc = 0, n_sync = 0, cyc = 0;
  // Core clock supplied on its own, config clock unrelated
  always #10 clk = ~clk;
  always #17 cfg_clk = ~cfg_clk;
  clkctl_core #(.LANES(LANES), .STABLE_CY(STABLE)) dut (.cfg_clk, .cfg_rst, .cfg_subclass,
    .cfg_tx_lid, .cfg_load, .cfg_busy, .cfg_rx_lid, .clk, .rst, .serdes_power_good(pg),
    .sysref_in, .sync_in, .ila_cfg_word3, .ila_cfg_valid, .tx_data_in, .tx_data_out,
    .tx_lane_identifier_field(tx_lid), .core_subclass, .core_ready, .lmfc_event,
    .sync_capture);
  clkctl_conv_model #(.LANES(LANES)) m (.clk, .sysref_in, .sync_in, .ila_cfg_word3,
    .ila_cfg_valid);
  always @(posedge clk)
  begin
    cyc++;
    n_lmfc += (lmfc_event === 1'b1);
    n_sync += (sync_capture === 1'b1);
    if (cyc == 30000)
    begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Scenarios
  task automatic load(input logic [1:0] sub, input logic [LW-1:0] lids, input bit spoil);
    @(negedge cfg_clk);
    {cfg_subclass, cfg_tx_lid, cfg_load} = {sub, lids, 1'b1};
    @(negedge cfg_clk);
    cfg_load = 1'b0;
    // A second load while busy must be dropped
    if (spoil)
    begin
      @(negedge cfg_clk);
      {cfg_tx_lid, cfg_load} = {~lids, 1'b1};
      @(negedge cfg_clk);
      cfg_load = 1'b0;
    end
    for (int i = 0; i < 80 && cfg_busy !== 1'b0; i++)
      @(negedge cfg_clk);
    repeat (4) @(negedge clk);
  endtask : load
  task automatic t_ready;
    int n;
    repeat (6) @(negedge clk);
    `CHK(core_subclass, SUBCLASS_RESET)
    `CHK({cfg_busy, core_ready, tx_data_out}, '0)
    {rst, cfg_rst} = 2'b00;
    repeat (20) @(negedge clk);
    `CHK(core_ready, 1'b0)
    pg = 1'b1;
    for (n = 0; n < 100 && core_ready !== 1'b1; n++)
      @(negedge clk);
    `CHK(n >= STABLE && core_ready === 1'b1, 1'b1)
  endtask : t_ready
  task automatic t_data;
    tx_data_in = 64'hA1B2C3D4_0F1E2D3C;
    @(negedge clk);
    `CHK(tx_data_out, 64'hA1B2C3D4_0F1E2D3C)
    tx_data_in = 64'h00FF7E81_FFFFFFFF;
    @(negedge clk);
    `CHK(tx_data_out, 64'h00FF7E81_FFFFFFFF)
  endtask : t_data
  task automatic t_lid;
    load(SUBCLASS_1, {5'h11, 5'h03}, 1'b0);
    `CHK(tx_lid, {5'h11, 5'h03})
    load(SUBCLASS_1, '0, 1'b1);
    `CHK(tx_lid, 10'h000)
    load(2'h3, {5'h05, 5'h05}, 1'b0);
    `CHK({core_subclass, tx_lid}, {SUBCLASS_1, 5'h05, 5'h05})
  endtask : t_lid
  task automatic t_sc1;
    int cnt[3] = '{1, 3, 4};
    int gap[3] = '{0, 0, 30};
    for (int k = 0; k < 3; k++)
    begin
      {n_lmfc, n_sync} = 0;
      m.ref_train(cnt[k], 12, gap[k]);
      m.sync_rise();
      `CHK({n_lmfc, n_sync}, {cnt[k], 32'h00000000})
    end
  endtask : t_sc1
  task automatic t_other(input logic [1:0] sub, input int exp_sync);
    load(sub, {5'h1F, 5'h00}, 1'b0);
    {n_lmfc, n_sync} = 0;
    m.ref_train(2, 12, 0);
    m.sync_rise();
    `CHK({n_lmfc, n_sync}, {32'h00000000, exp_sync})
  endtask : t_other
  task automatic t_rx;
    m.send_ila(0, 5'h16);
    m.send_ila(1, 5'h09);
    repeat (12) @(negedge cfg_clk);
    `CHK(cfg_rx_lid, {5'h09, 5'h16})
  endtask : t_rx
  initial
  begin
    t_ready();
    t_data();
    t_lid();
    t_sc1();
    t_other(SUBCLASS_2, 1);
    t_other(SUBCLASS_0, 0);
    t_rx();
    final_report();
  end
endmodule : test_clkctl_core
`default_nettype wire
